// [rtl/eip_pkg.sv]
package eip_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int EXT_N  = 5;
   localparam int WAKE_N = 8;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_PFR_A    = 4'h0;
   localparam logic [3:0] ADDR_PFR_B    = 4'h1;
   localparam logic [3:0] ADDR_PFR_WAKE = 4'h2;
   localparam logic [3:0] ADDR_EDGE     = 4'h3;
   localparam logic [3:0] ADDR_EXT_FLAG = 4'h4;
   localparam logic [3:0] ADDR_WK_FLAG  = 4'h5;
   localparam logic [3:0] ADDR_EXT_MASK = 4'h6;
   localparam logic [3:0] ADDR_WK_MASK  = 4'h7;

   // ----------------------------------------------------------------
   // field positions and masks
   // ----------------------------------------------------------------
   localparam int POS_RQ0 = 0;
   localparam int POS_RQ1 = 1;
   localparam int POS_RQ2 = 2;
   localparam int POS_RQ3 = 3;
   localparam int POS_RQ4 = 4;
   localparam logic [7:0] PFR_A_MASK = 8'h0E;
   localparam logic [7:0] PFR_B_MASK = 8'h11;
   localparam logic [7:0] EXT_MASK   = 8'h1F;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_REG  = 8'h00;
   localparam logic [7:0] RST_PINS = 8'hFF;

   // ----------------------------------------------------------------
   // bus request carrier
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } eip_bus_req_s;

endpackage

// [rtl/eip_pin_flags.sv]
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module eip_pin_flags
   import eip_pkg::*;
(
   // clock and reset
   input  wire logic               i_clock,
   input  wire logic               i_arst_n,
   // register port
   input  wire eip_bus_req_s       i_bus,
   output logic [DATA_W-1:0]       o_rdata,
   // pins
   input  wire logic [EXT_N-1:0]   i_request_pin_n,
   input  wire logic [WAKE_N-1:0]  i_wakeup_pin_n,
   // interrupt
   output logic                    o_irq
);

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   function automatic logic is_pfr(input logic [ADDR_W-1:0] a);
      return (a == ADDR_PFR_A) || (a == ADDR_PFR_B) ||
             (a == ADDR_PFR_WAKE);
   endfunction

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [EXT_N-1:0]  ext_meta;
   logic [EXT_N-1:0]  ext_pin_s;
   logic [WAKE_N-1:0] wk_meta;
   logic [WAKE_N-1:0] wk_pin_s;

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ext_meta  <= RST_PINS[EXT_N-1:0];
         ext_pin_s <= RST_PINS[EXT_N-1:0];
         wk_meta   <= RST_PINS;
         wk_pin_s  <= RST_PINS;
      end else begin
         ext_meta  <= i_request_pin_n;
         ext_pin_s <= ext_meta;
         wk_meta   <= i_wakeup_pin_n;
         wk_pin_s  <= wk_meta;
      end
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] pfr_a;
   logic [DATA_W-1:0] pfr_b;
   logic [WAKE_N-1:0] pfr_wake;
   logic [EXT_N-1:0]  edge_sel;
   logic [EXT_N-1:0]  ext_flag;
   logic [WAKE_N-1:0] wk_flag;
   logic [EXT_N-1:0]  ext_mask;
   logic [WAKE_N-1:0] wk_mask;
   logic [EXT_N-1:0]  ext_gate_q;
   logic [WAKE_N-1:0] wk_gate_q;
   logic              last_pfr_wr;
   logic [DATA_W-1:0] rdata;

   logic [DATA_W-1:0] next_pfr_a;
   logic [DATA_W-1:0] next_pfr_b;
   logic [WAKE_N-1:0] next_pfr_wake;
   logic [EXT_N-1:0]  next_edge_sel;
   logic [EXT_N-1:0]  next_ext_flag;
   logic [WAKE_N-1:0] next_wk_flag;
   logic [EXT_N-1:0]  next_ext_mask;
   logic [WAKE_N-1:0] next_wk_mask;
   logic              next_last_pfr_wr;
   logic [DATA_W-1:0] next_rdata;

   logic [EXT_N-1:0]  ext_sel;
   logic [EXT_N-1:0]  ext_gate;
   logic [WAKE_N-1:0] wk_gate;
   logic [EXT_N-1:0]  ext_evt;
   logic [WAKE_N-1:0] wk_evt;
   logic              clr_ok;

   // ----------------------------------------------------------------
   // next values
   // ----------------------------------------------------------------
   always_comb begin
      // select bits gathered per request pin
      ext_sel[POS_RQ0] = pfr_b[POS_RQ0];
      ext_sel[POS_RQ1] = pfr_a[POS_RQ1];
      ext_sel[POS_RQ2] = pfr_a[POS_RQ2];
      ext_sel[POS_RQ3] = pfr_a[POS_RQ3];
      ext_sel[POS_RQ4] = pfr_b[POS_RQ4];
      // deselected pins look high
      ext_gate = ext_pin_s | ~ext_sel;
      wk_gate  = wk_pin_s | ~pfr_wake;
      // request pins: edge per pin polarity; wakeup pins: falling edge only
      ext_evt = (edge_sel & ext_gate & ~ext_gate_q) |
                (~edge_sel & ~ext_gate & ext_gate_q);
      wk_evt  = ~wk_gate & wk_gate_q;
      // clear ignored on the first bus access after a select write
      clr_ok = i_bus.wr && !last_pfr_wr;

      next_pfr_a    = pfr_a;
      next_pfr_b    = pfr_b;
      next_pfr_wake = pfr_wake;
      next_edge_sel = edge_sel;
      next_ext_mask = ext_mask;
      next_wk_mask  = wk_mask;
      next_ext_flag = ext_flag;
      next_wk_flag  = wk_flag;
      if (i_bus.wr) begin
         case (i_bus.addr)
            ADDR_PFR_A:    next_pfr_a    = i_bus.wdata & PFR_A_MASK;
            ADDR_PFR_B:    next_pfr_b    = i_bus.wdata & PFR_B_MASK;
            ADDR_PFR_WAKE: next_pfr_wake = i_bus.wdata;
            ADDR_EDGE:     next_edge_sel = i_bus.wdata[EXT_N-1:0];
            ADDR_EXT_MASK: next_ext_mask = i_bus.wdata[EXT_N-1:0];
            ADDR_WK_MASK:  next_wk_mask  = i_bus.wdata;
            default:       ;
         endcase
      end
      // write zero clears, write one keeps
      if (clr_ok && i_bus.addr == ADDR_EXT_FLAG) begin
         next_ext_flag = ext_flag & i_bus.wdata[EXT_N-1:0];
      end
      if (clr_ok && i_bus.addr == ADDR_WK_FLAG) begin
         next_wk_flag = wk_flag & i_bus.wdata;
      end
      // set wins over clear
      next_ext_flag = next_ext_flag | ext_evt;
      next_wk_flag  = next_wk_flag | wk_evt;

      next_last_pfr_wr = last_pfr_wr;
      if (i_bus.wr || i_bus.rd) begin
         next_last_pfr_wr = i_bus.wr && is_pfr(i_bus.addr);
      end

      next_rdata = RST_REG;
      if (i_bus.rd) begin
         case (i_bus.addr)
            ADDR_PFR_A:    next_rdata = pfr_a;
            ADDR_PFR_B:    next_rdata = pfr_b;
            ADDR_PFR_WAKE: next_rdata = pfr_wake;
            ADDR_EDGE:     next_rdata = {3'h0, edge_sel};
            ADDR_EXT_FLAG: next_rdata = {3'h0, ext_flag};
            ADDR_WK_FLAG:  next_rdata = wk_flag;
            ADDR_EXT_MASK: next_rdata = {3'h0, ext_mask};
            ADDR_WK_MASK:  next_rdata = wk_mask;
            default:       next_rdata = RST_REG;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pfr_a       <= RST_REG;
         pfr_b       <= RST_REG;
         pfr_wake    <= RST_REG;
         edge_sel    <= RST_REG[EXT_N-1:0];
         ext_flag    <= RST_REG[EXT_N-1:0];
         wk_flag     <= RST_REG;
         ext_mask    <= RST_REG[EXT_N-1:0];
         wk_mask     <= RST_REG;
         ext_gate_q  <= RST_PINS[EXT_N-1:0];
         wk_gate_q   <= RST_PINS;
         last_pfr_wr <= 1'b0;
         rdata       <= RST_REG;
      end else begin
         pfr_a       <= next_pfr_a;
         pfr_b       <= next_pfr_b;
         pfr_wake    <= next_pfr_wake;
         edge_sel    <= next_edge_sel;
         ext_flag    <= next_ext_flag;
         wk_flag     <= next_wk_flag;
         ext_mask    <= next_ext_mask;
         wk_mask     <= next_wk_mask;
         ext_gate_q  <= ext_gate;
         wk_gate_q   <= wk_gate;
         last_pfr_wr <= next_last_pfr_wr;
         rdata       <= next_rdata;
      end
   end

   assign o_rdata = rdata;
   assign o_irq   = |(ext_flag & ext_mask) || |(wk_flag & wk_mask);

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_arst_n);

   sequence s_clr_ext;
      i_bus.wr && i_bus.addr == ADDR_EXT_FLAG;
   endsequence

   sequence s_read;
      i_bus.rd && i_bus.addr == ADDR_EXT_FLAG;
   endsequence

   sequence s_clr_wk;
      i_bus.wr && i_bus.addr == ADDR_WK_FLAG;
   endsequence

   for (genvar g = 0; g < EXT_N; g++) begin : g_ext_chk
      spur_fall_a: assert property (
         $rose(ext_sel[g]) && !ext_pin_s[g] && !edge_sel[g]
         |=> ext_flag[g])
         else $error("select rise did not set request flag");
      spur_rise_a: assert property (
         $fell(ext_sel[g]) && !ext_pin_s[g] && edge_sel[g]
         |=> ext_flag[g])
         else $error("select fall did not set request flag");
      ext_edge_a: assert property (
         ext_sel[g] && $stable(ext_sel[g]) && $stable(edge_sel[g]) &&
         (edge_sel[g] ? $rose(ext_pin_s[g]) : $fell(ext_pin_s[g]))
         |=> ext_flag[g])
         else $error("selected edge did not set request flag");
      clr_block_a: assert property (
         s_clr_ext ##0 (last_pfr_wr && ext_flag[g]) |=> ext_flag[g])
         else $error("clear right after select write took effect");
      ext_keep_a: assert property (
         s_clr_ext ##0 (ext_flag[g] && i_bus.wdata[g]) |=> ext_flag[g])
         else $error("writing one to a request flag cleared it");
      ext_sticky_a: assert property (
         ext_flag[g] && !(i_bus.wr && i_bus.addr == ADDR_EXT_FLAG)
         |=> ext_flag[g])
         else $error("request flag cleared without a write");
   end

   for (genvar w = 0; w < WAKE_N; w++) begin : g_wk_chk
      wake_spur_a: assert property (
         $rose(pfr_wake[w]) && !wk_pin_s[w] |=> wk_flag[w])
         else $error("wakeup select rise did not set flag");
      wake_fall_a: assert property (
         pfr_wake[w] && $stable(pfr_wake[w]) && $fell(wk_pin_s[w])
         |=> wk_flag[w])
         else $error("wakeup falling edge did not set flag");
      wk_block_a: assert property (
         s_clr_wk ##0 (last_pfr_wr && wk_flag[w]) |=> wk_flag[w])
         else $error("wakeup clear right after select write took effect");
      wk_keep_a: assert property (
         s_clr_wk ##0 (wk_flag[w] && i_bus.wdata[w]) |=> wk_flag[w])
         else $error("writing one to a wakeup flag cleared it");
      wk_clear_a: assert property (
         s_clr_wk ##0 (!last_pfr_wr && !i_bus.wdata[w] && !wk_evt[w])
         |=> !wk_flag[w])
         else $error("writing zero did not clear a wakeup flag");
      wk_sticky_a: assert property (
         wk_flag[w] && !(i_bus.wr && i_bus.addr == ADDR_WK_FLAG)
         |=> wk_flag[w])
         else $error("wakeup flag cleared without a write");
   end

   clr_zero_a: assert property (
      s_clr_ext ##0 !last_pfr_wr |=>
      ((ext_flag & ~$past(i_bus.wdata[EXT_N-1:0]) & ~$past(ext_evt))
       == '0) && ((ext_flag & $past(ext_flag) & ~$past(ext_evt)) ==
       ($past(ext_flag) & $past(i_bus.wdata[EXT_N-1:0]) &
        ~$past(ext_evt))))
      else $error("request flag write did not follow zero-clear");

   read_data_a: assert property (
      s_read |=> (o_rdata == {3'h0, $past(ext_flag)}) ##1
      (o_rdata == '0 || $past(i_bus.rd)))
      else $error("read data not in the cycle after the strobe");

   wk_read_a: assert property (
      i_bus.rd && i_bus.addr == ADDR_WK_FLAG |=> o_rdata == $past(wk_flag))
      else $error("wakeup flags not read back in the next cycle");

   rdata_idle_a: assert property (
      !i_bus.rd |=> o_rdata == '0)
      else $error("read data present without a read strobe");

   irq_mask_a: assert property (
      ext_mask == '0 && wk_mask == '0 |-> !o_irq)
      else $error("interrupt high with every source masked");

   logic irq_src_chg;
   assign irq_src_chg = (ext_flag != next_ext_flag) ||
                        (wk_flag != next_wk_flag) ||
                        (ext_mask != next_ext_mask) ||
                        (wk_mask != next_wk_mask);

   irq_out_a: assert property (
      $rose(o_irq) |-> $past(irq_src_chg))
      else $error("interrupt rose without a flag or mask change");

endmodule // eip_pin_flags

// [verif/eip_pin_model.sv]
`timescale 1ns/1ps
module eip_pin_model
   import eip_pkg::*;
(
   // clock and command
   input  wire logic              i_clock,
   input  wire logic [EXT_N-1:0]  i_ext_low,
   input  wire logic [WAKE_N-1:0] i_wk_low,
   // pins
   output logic [EXT_N-1:0]       o_request_pin_n,
   output logic [WAKE_N-1:0]      o_wakeup_pin_n
);
   // pins idle high, pulled low only on command
   always_ff @(posedge i_clock) begin
      o_request_pin_n <= ~i_ext_low;
      o_wakeup_pin_n  <= ~i_wk_low;
   end
endmodule // eip_pin_model

// [verif/eip_pin_flags_bench.sv]
`timescale 1ns/1ps
module eip_pin_flags_bench import eip_pkg::*;;
   // -------------------------------------------------------------
   // signals
   // -------------------------------------------------------------
   logic              clk;
   logic              rst_n;
   eip_bus_req_s      bus;
   logic [DATA_W-1:0] rdata;
   logic              irq;
   logic [EXT_N-1:0]  ext_low;
   logic [WAKE_N-1:0] wk_low;
   logic [EXT_N-1:0]  rq_pin_n;
   logic [WAKE_N-1:0] wk_pin_n;
   int                error_cnt;
   int                check_count;
   int                cycles = 0;

   eip_pin_flags dut (.i_clock(clk), .i_arst_n(rst_n), .i_bus(bus),
      .o_rdata(rdata), .i_request_pin_n(rq_pin_n),
      .i_wakeup_pin_n(wk_pin_n), .o_irq(irq));
   eip_pin_model pins_far (.i_clock(clk), .i_ext_low(ext_low),
      .i_wk_low(wk_low), .o_request_pin_n(rq_pin_n),
      .o_wakeup_pin_n(wk_pin_n));

   // -------------------------------------------------------------
   // clock and timeout
   // -------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         wrap_up();
      end
   end

   // -------------------------------------------------------------
   // tasks
   // -------------------------------------------------------------
   task automatic wrap_up();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      @(negedge clk);
      check(rdata, exp);
   endtask
   task automatic pins(input logic [4:0] e, input logic [7:0] w);
      @(posedge clk);
      ext_low <= e;
      wk_low  <= w;
      idle(6);
   endtask
   // select write, blocked clear, spaced clear
   task automatic sel_clr(input logic [3:0] a, input logic [7:0] d,
                          input logic [3:0] fa, input logic [7:0] m);
      wr(a, d);
      idle(3);
      wr(fa, 8'h00);
      rd(fa, m);
      wr(fa, 8'hFF);
      rd(fa, m);
      wr(fa, 8'h00);
      rd(fa, 8'h00);
   endtask

   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task automatic t_regs();
      logic [7:0] ex [8] = '{8'h0E, 8'h11, 8'hFF, 8'h1F,
                             8'h00, 8'h00, 8'h1F, 8'hFF};
      for (int a = 0; a < 10; a++) rd(a[3:0], 8'h00);
      wr(4'h9, 8'hFF);
      rd(4'h9, 8'h00);
      for (int a = 0; a < 8; a++) begin
         wr(a[3:0], 8'hFF);
         rd(a[3:0], ex[a]);
         wr(a[3:0], 8'h00);
      end
      rd(ADDR_EXT_FLAG, 8'h00);
      check({7'h00, irq}, 8'h00);
   endtask
   task automatic t_ext();
      logic [7:0] m;
      logic [3:0] pa;
      logic [3:0] oa;
      for (int n = 0; n < EXT_N; n++) begin
         m  = 8'h01 << n;
         pa = (n == 0 || n == 4) ? ADDR_PFR_B : ADDR_PFR_A;
         oa = (n == 0 || n == 4) ? ADDR_PFR_A : ADDR_PFR_B;
         pins(m[4:0], 8'h00);
         wr(oa, m);
         idle(3);
         rd(ADDR_EXT_FLAG, 8'h00);
         sel_clr(pa, m, ADDR_EXT_FLAG, m);
         wr(ADDR_EDGE, m);
         sel_clr(pa, 8'h00, ADDR_EXT_FLAG, m);
         wr(pa, m);
         idle(3);
         rd(ADDR_EXT_FLAG, 8'h00);
         pins(5'h00, 8'h00);
         rd(ADDR_EXT_FLAG, m);
         wr(ADDR_EXT_MASK, m);
         idle(1);
         check({7'h00, irq}, 8'h01);
         wr(ADDR_EXT_FLAG, 8'h00);
         idle(1);
         check({7'h00, irq}, 8'h00);
         wr(ADDR_EXT_MASK, 8'h00);
         wr(ADDR_EDGE, 8'h00);
         wr(pa, 8'h00);
      end
   endtask
   task automatic t_wake();
      logic [7:0] m;
      for (int n = 0; n < WAKE_N; n++) begin
         m = 8'h01 << n;
         pins(5'h00, m);
         sel_clr(ADDR_PFR_WAKE, m, ADDR_WK_FLAG, m);
         pins(5'h00, 8'h00);
         rd(ADDR_WK_FLAG, 8'h00);
         pins(5'h00, m);
         rd(ADDR_WK_FLAG, m);
         wr(ADDR_WK_MASK, m);
         idle(1);
         check({7'h00, irq}, 8'h01);
         wr(ADDR_WK_MASK, 8'h00);
         idle(1);
         check({7'h00, irq}, 8'h00);
         wr(ADDR_WK_FLAG, 8'h00);
         pins(5'h00, 8'h00);
      end
   endtask

   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      bus = '0;
      ext_low = '0;
      wk_low = '0;
      error_cnt = 0;
      check_count = 0;
      idle(6);
      rst_n <= 1'b1;
      t_regs();
      t_ext();
      t_wake();
      wrap_up();
   end
endmodule // eip_pin_flags_bench
